// ### design/iad_pkg.sv
`default_nettype none
// ============================================================================
// Shared constants for the IDE address decode block.
package iad_pkg;
   // Width of the host I/O address that the decoder compares.
   localparam int unsigned ADDR_W = 10;
   // Primary command block, first and last address.
   localparam logic [9:0] PRI_CMD_LO = 10'h1F0;
   localparam logic [9:0] PRI_CMD_HI = 10'h1F7;
   // Secondary command block, first and last address.
   localparam logic [9:0] SEC_CMD_LO = 10'h170;
   localparam logic [9:0] SEC_CMD_HI = 10'h177;
   // Primary control block, first and last address.
   localparam logic [9:0] PRI_CTL_LO = 10'h3F6;
   localparam logic [9:0] PRI_CTL_HI = 10'h3F7;
   // Secondary control block, first and last address.
   localparam logic [9:0] SEC_CTL_LO = 10'h376;
   localparam logic [9:0] SEC_CTL_HI = 10'h377;
   // Eight-bit host window used in XT mode.
   localparam logic [9:0] XT_CMD_LO  = 10'h320;
   localparam logic [9:0] XT_CMD_HI  = 10'h323;
   // Pin synchroniser width and its idle value after reset.
   localparam int unsigned SYNC_W    = 17;
   // Bits: addr[9:0], read_n, write_n, xfer16_n, strap, ide d7, host d7, disk change.
   // Idle means address zero, both strobes and the sixteen-bit request high.
   localparam logic [16:0] SYNC_INIT = 17'h00070;
   // Edges after reset release before the synchronised strap shows the pin level.
   localparam logic [2:0]  STRAP_SETTLE = 3'h4;
   // Phase of the strap capture: Gray coded along the path.
   typedef enum logic [1:0] {
      IAD_CAPTURE = 2'h0,
      IAD_RUN     = 2'h1
   } iad_phase_type;
   // True when an address lies inside an inclusive range.
   function automatic logic in_range(input logic [9:0] a, input logic [9:0] lo,
                                     input logic [9:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction
endpackage
`default_nettype wire

// ### design/iad_sync_if.sv
`default_nettype none
// ============================================================================
// Carrier between the decoder and its pin synchroniser.
interface iad_sync_if #(parameter int unsigned W = 17);
   logic [W-1:0] raw;   // Pin levels straight from outside.
   logic [W-1:0] clean; // Levels after the synchroniser has agreed on them.
   modport sync_side (input raw, output clean);
   modport user_side (output raw, input clean);
endinterface
`default_nettype wire

// ### design/iad_sync.sv
`default_nettype none
// ============================================================================
// Three-stage pin synchroniser; a change is taken once stages two and three agree.
module iad_sync #(
   parameter int unsigned        W    = 17,
   parameter logic [W-1:0]       INIT = '0
) (
   input  wire logic             clk,
   input  wire logic             resetn,
   iad_sync_if.sync_side         sif
);
   // All state of the synchroniser in one packed struct.
   typedef struct packed {
      logic [W-1:0] s1;  // Metastability catcher, read only by s2.
      logic [W-1:0] s2;  // Second stage.
      logic [W-1:0] s3;  // Third stage.
      logic [W-1:0] out; // Accepted level.
   } iad_sync_st_type;

   iad_sync_st_type st_r;
   iad_sync_st_type st_nxt;

   // ==========================================================================
   // Next state: a bit moves to the output only when s2 and s3 agree.
   always_comb begin
      st_nxt     = st_r;
      st_nxt.s1  = sif.raw;
      st_nxt.s2  = st_r.s1;
      st_nxt.s3  = st_r.s2;
      for (int i = 0; i < int'(W); i++) begin
         if (st_r.s2[i] == st_r.s3[i]) begin
            st_nxt.out[i] = st_r.s3[i];
         end
      end
   end

   // ==========================================================================
   // Registers take only constants under reset.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_r <= {INIT, INIT, INIT, INIT};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign sif.clean = st_r.out;
endmodule // iad_sync
`default_nettype wire

// ### design/iad_decode.sv
`default_nettype none
// Behaviour
// R01 - AT primary: low enable on 1F0-1F7, 3F6-3F7
// R02 - AT secondary: low enable 170-177, 376-377
// R03 - XT: low enable on 320-323
// R04 - High enable only AT and sixteen-bit active
// R05 - High enable only on command block range
// R06 - XT never asserts high enable
// R07 - AT command select on 1F0/170 block
// R08 - XT command select on 320-323
// R09 - AT control select on 3F6-3F7 or 376-377
// R10 - XT control select on 3F6-3F7
// R11 - Adapter mode latches address strap at reset
// R12 - Drive signals sixteen-bit transfers low
// R13 - Read of control top returns disk change; the code does this in AT mode only
// R14 - All selects high when disabled or unmatched
// R15 - Held setting picks primary or secondary uniformly
module iad_decode (
   input  wire logic clk,                    // 50 MHz device clock.
   input  wire logic resetn,                 // Asynchronous reset, active low.
   input  wire logic [9:0] host_addr,        // Host I/O address pins.
   input  wire logic host_read_n,            // Host I/O read strobe.
   input  wire logic host_write_n,           // Host I/O write strobe.
   input  wire logic sixteen_bit_xfer_n,     // Drive asks for 16-bit transfers.
   input  wire logic ide_addr_strap,         // Address-control strap pin.
   input  wire logic floppy_disk_change,     // Disk change status pin.
   input  wire logic ide_enable,             // IDE decode enabled.
   input  wire logic xt_mode,                // High selects XT, low selects AT.
   input  wire logic adapter_mode,           // Strap decides the address range.
   input  wire logic cfg_secondary,          // Secondary range when not adapter.
   input  wire logic host_data_bit7_in,      // Host data bit 7, pin level.
   output logic      host_data_bit7_out,     // Host data bit 7, driven level.
   output logic      host_data_bit7_oe_n,    // Low while driving host bit 7.
   input  wire logic ide_data_bit7_in,       // Drive data bit 7, pin level.
   output logic      ide_data_bit7_out,      // Drive data bit 7, driven level.
   output logic      ide_data_bit7_oe_n,     // Low while driving drive bit 7.
   output logic      ide_low_byte_enable_n,  // Low byte buffer enable.
   output logic      ide_high_byte_enable_n, // High byte buffer enable.
   output logic      disk_select_cmd_n,      // Command block chip select.
   output logic      disk_select_ctl_n,      // Control block chip select.
   output logic      secondary_active        // Range in use, for status.
);
   // ==========================================================================
   // Pin synchronisation.
   iad_sync_if #(.W(iad_pkg::SYNC_W)) sif ();

   assign sif.raw = {host_addr, host_read_n, host_write_n, sixteen_bit_xfer_n,
                     ide_addr_strap, ide_data_bit7_in, host_data_bit7_in,
                     floppy_disk_change};

   iad_sync #(.W(iad_pkg::SYNC_W), .INIT(iad_pkg::SYNC_INIT)) u_sync (
      .clk    (clk),
      .resetn (resetn),
      .sif    (sif)
   );

   logic [9:0] addr_s;     // Accepted address.
   logic       rd_n_s;     // Accepted read strobe.
   logic       wr_n_s;     // Accepted write strobe.
   logic       x16_n_s;    // Accepted sixteen-bit indication.
   logic       strap_s;    // Accepted strap level.
   logic       ide_d7_s;   // Accepted drive bit 7.
   logic       host_d7_s;  // Accepted host bit 7.
   logic       dskchg_s;   // Accepted disk change.

   assign {addr_s, rd_n_s, wr_n_s, x16_n_s, strap_s, ide_d7_s, host_d7_s, dskchg_s} =
          sif.clean;

   // ==========================================================================
   // State of the block in one packed struct.
   typedef struct packed {
      iad_pkg::iad_phase_type phase; // Strap capture or normal running.
      logic [2:0] settle;            // Edges spent waiting for the strap.
      logic strap;                   // Latched address strap.
      logic lo_n;                    // Low byte enable.
      logic hi_n;                    // High byte enable.
      logic cmd_n;                   // Command select.
      logic ctl_n;                   // Control select.
      logic hd7;                     // Host bit 7 value.
      logic hd7_oe_n;                // Host bit 7 drive enable.
      logic id7;                     // Drive bit 7 value.
      logic id7_oe_n;                // Drive bit 7 drive enable.
   } iad_state_type;

   iad_state_type st_r;
   iad_state_type st_nxt;

   // Decode terms, shared by next-state logic and assertions.
   logic sec_sel;   // Secondary range chosen.
   logic at_cmd;    // AT command block hit.
   logic at_ctl;    // AT control block hit.
   logic xt_cmd;    // XT window hit.
   logic xt_ctl;    // XT control hit.
   logic rd_top;    // Host read of the top control address.

   // ==========================================================================
   // Range selection and address match.
   always_comb begin
      // The strap only counts once captured; until then the held setting rules.
      if (adapter_mode && st_r.phase == iad_pkg::IAD_RUN) begin
         sec_sel = st_r.strap; // R11
      end else begin
         sec_sel = cfg_secondary; // R15
      end
      if (sec_sel) begin
         at_cmd = iad_pkg::in_range(addr_s, iad_pkg::SEC_CMD_LO, iad_pkg::SEC_CMD_HI);
         at_ctl = iad_pkg::in_range(addr_s, iad_pkg::SEC_CTL_LO, iad_pkg::SEC_CTL_HI);
         rd_top = !rd_n_s && addr_s == iad_pkg::SEC_CTL_HI;
      end else begin
         at_cmd = iad_pkg::in_range(addr_s, iad_pkg::PRI_CMD_LO, iad_pkg::PRI_CMD_HI);
         at_ctl = iad_pkg::in_range(addr_s, iad_pkg::PRI_CTL_LO, iad_pkg::PRI_CTL_HI);
         rd_top = !rd_n_s && addr_s == iad_pkg::PRI_CTL_HI;
      end
      xt_cmd = iad_pkg::in_range(addr_s, iad_pkg::XT_CMD_LO, iad_pkg::XT_CMD_HI);
      xt_ctl = iad_pkg::in_range(addr_s, iad_pkg::PRI_CTL_LO, iad_pkg::PRI_CTL_HI);
   end

   // ==========================================================================
   // Next state of selects, data bit 7 steering and strap capture.
   always_comb begin
      st_nxt          = st_r;
      st_nxt.lo_n     = 1'b1; // R14
      st_nxt.hi_n     = 1'b1; // R14
      st_nxt.cmd_n    = 1'b1; // R14
      st_nxt.ctl_n    = 1'b1; // R14
      st_nxt.hd7_oe_n = 1'b1;
      st_nxt.id7_oe_n = 1'b1;
      // A reset flop may only load constants and the synchroniser is held in
      // reset too, so the strap is followed until the pin level has crossed
      // the three stages. The strap must therefore stay steady a few cycles
      // past the release of reset, as a strap resistor does.
      case (st_r.phase)
         iad_pkg::IAD_CAPTURE: begin
            st_nxt.strap  = strap_s; // R11
            st_nxt.settle = st_r.settle + 3'h1;
            if (st_r.settle == iad_pkg::STRAP_SETTLE) begin
               st_nxt.phase = iad_pkg::IAD_RUN;
            end
         end
         iad_pkg::IAD_RUN: begin
            st_nxt.phase = iad_pkg::IAD_RUN;
         end
         default: begin
            st_nxt.phase = iad_pkg::IAD_CAPTURE;
         end
      endcase
      if (ide_enable) begin
         if (xt_mode) begin
            // Eight-bit window only; the high byte lane stays idle.
            st_nxt.lo_n  = !xt_cmd; // R03
            st_nxt.cmd_n = !xt_cmd; // R08
            st_nxt.ctl_n = !xt_ctl; // R10
            st_nxt.hi_n  = 1'b1;    // R06
         end else begin
            st_nxt.lo_n  = !(at_cmd || at_ctl);       // R01 R02
            // The drive's indication is trusted only in AT mode.
            st_nxt.hi_n  = !(at_cmd && !x16_n_s);     // R04 R05 R12
            st_nxt.cmd_n = !at_cmd;                   // R07
            st_nxt.ctl_n = !at_ctl;                   // R09
            // Bit 7 buffering; a read of the top control address answers the
            // disk change bit instead of the drive's own bit.
            if (!rd_n_s && (at_cmd || at_ctl)) begin
               st_nxt.hd7_oe_n = 1'b0;
               st_nxt.hd7      = rd_top ? dskchg_s : ide_d7_s; // R13
            end else if (!wr_n_s && (at_cmd || at_ctl)) begin
               st_nxt.id7_oe_n = 1'b0;
               st_nxt.id7      = host_d7_s; // R13
            end
         end
      end
   end

   // ==========================================================================
   // State register; every field takes a constant under reset.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_r <= '{phase: iad_pkg::IAD_CAPTURE, settle: 3'h0, strap: 1'b0,
                   lo_n: 1'b1, hi_n: 1'b1, cmd_n: 1'b1, ctl_n: 1'b1, hd7: 1'b0,
                   hd7_oe_n: 1'b1, id7: 1'b0, id7_oe_n: 1'b1};
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs straight from flip-flops, except secondary_active, which is sec_sel decoded without a register.
   assign ide_low_byte_enable_n  = st_r.lo_n;
   assign ide_high_byte_enable_n = st_r.hi_n;
   assign disk_select_cmd_n      = st_r.cmd_n;
   assign disk_select_ctl_n      = st_r.ctl_n;
   assign host_data_bit7_out     = st_r.hd7;
   assign host_data_bit7_oe_n    = st_r.hd7_oe_n;
   assign ide_data_bit7_out      = st_r.id7;
   assign ide_data_bit7_oe_n     = st_r.id7_oe_n;
   assign secondary_active       = sec_sel;

   // ==========================================================================
   // Assertions guarding the decode, one cycle after the accepted inputs.
   at_low_en_a: assert property (@(posedge clk) disable iff (!resetn) // R01
      (ide_enable && !xt_mode && !sec_sel && addr_s == iad_pkg::PRI_CTL_LO)
      |=> !ide_low_byte_enable_n)
      else $error("Low enable missing on primary control access.");
   sec_low_en_a: assert property (@(posedge clk) disable iff (!resetn) // R02
      (ide_enable && !xt_mode && sec_sel && addr_s == iad_pkg::SEC_CMD_LO)
      |=> !ide_low_byte_enable_n && !disk_select_cmd_n)
      else $error("Secondary command access not enabled.");
   xt_low_en_a: assert property (@(posedge clk) disable iff (!resetn) // R03
      (ide_enable && xt_mode) |=> (ide_low_byte_enable_n != $past(xt_cmd)))
      else $error("XT low enable does not follow the XT window.");
   hi_needs16_a: assert property (@(posedge clk) disable iff (!resetn) // R04
      !ide_high_byte_enable_n |-> !$past(x16_n_s) && !$past(xt_mode))
      else $error("High enable without sixteen-bit indication.");
   hi_cmd_only_a: assert property (@(posedge clk) disable iff (!resetn) // R05
      !ide_high_byte_enable_n |-> !disk_select_cmd_n && disk_select_ctl_n)
      else $error("High enable outside the command block.");
   xt_hi_idle_a: assert property (@(posedge clk) disable iff (!resetn) // R06
      $past(xt_mode) |-> ide_high_byte_enable_n)
      else $error("High enable asserted in XT mode.");
   xt_ctl_sel_a: assert property (@(posedge clk) disable iff (!resetn) // R10
      (ide_enable && xt_mode && addr_s == iad_pkg::PRI_CTL_HI)
      |=> !disk_select_ctl_n && ide_low_byte_enable_n)
      else $error("XT control select wrong.");
   off_idle_a: assert property (@(posedge clk) disable iff (!resetn) // R14
      !ide_enable |=> ide_low_byte_enable_n && ide_high_byte_enable_n &&
                      disk_select_cmd_n && disk_select_ctl_n)
      else $error("Select active while IDE disabled.");
   dskchg_rd_a: assert property (@(posedge clk) disable iff (!resetn) // R13
      (ide_enable && !xt_mode && rd_top)
      |=> !host_data_bit7_oe_n && host_data_bit7_out == $past(dskchg_s))
      else $error("Disk change not returned on control read.");
   strap_hold_a: assert property (@(posedge clk) disable iff (!resetn) // R11
      (st_r.phase == iad_pkg::IAD_RUN) |=> $stable(st_r.strap))
      else $error("Latched strap changed after capture.");

   at16_cv: cover property (@(posedge clk) disable iff (!resetn)
      !ide_high_byte_enable_n && !ide_low_byte_enable_n);
   xt_cv: cover property (@(posedge clk) disable iff (!resetn)
      $past(xt_mode) && !disk_select_cmd_n);
   dskchg_cv: cover property (@(posedge clk) disable iff (!resetn)
      !host_data_bit7_oe_n && $past(rd_top));
endmodule // iad_decode
`default_nettype wire

// ### verification/iad_drive_model.sv
`default_nettype none
// ============================================================================
// Drive model: the disk side of the decoder, bit 7 of its data bus and its
// request for sixteen-bit transfers.
module iad_drive_model (
   input  wire logic want16_n,           // Bench's wish for 16-bit transfers.
   input  wire logic drive_bit7,         // Value the drive puts on bit 7.
   input  wire logic ide_data_bit7_out,  // Level the decoder drives.
   input  wire logic ide_data_bit7_oe_n, // Low while the decoder drives.
   output logic      sixteen_bit_xfer_n, // Low asks for 16-bit transfers.
   output logic      ide_data_bit7_in    // Resolved level of the wire.
);
   timeunit 1ns;
   timeprecision 1ps;
   // The request is low for 16-bit and high for 8-bit transfers.
   assign sixteen_bit_xfer_n = want16_n;
   // The wire carries the decoder's level while it drives, else the drive's.
   // Contention is not modelled, so a wrong enable shows as a wrong value.
   assign ide_data_bit7_in = ide_data_bit7_oe_n ? drive_bit7 : ide_data_bit7_out;
endmodule // iad_drive_model
`default_nettype wire

// ### verification/ide_address_decode_bench.sv
`default_nettype none
// ============================================================================
// Self-checking bench for the IDE address decoder.
module ide_address_decode_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, resetn = 1'b0;           // Clock and reset.
   logic [9:0] host_addr = 10'h000;           // Host address.
   logic rd_n = 1'b1, wr_n = 1'b1;            // Host strobes.
   logic want16_n = 1'b1, drive_bit7 = 1'b0;  // Drive model controls.
   logic strap = 1'b0, fdc = 1'b0;            // Strap and disk change.
   logic en = 1'b0, xt = 1'b0, adapter = 1'b0; // Configuration.
   logic sec = 1'b0, hbit7_in = 1'b0;         // Range and host bit 7.
   logic hb7_out, hb7_oe_n, ib7_out, ib7_oe_n; // Bit 7 outputs.
   logic x16_n, ib7_in, lo_n, hi_n, cmd_n, ctl_n, sec_act; // Other nets.
   logic [3:0] sels;                           // Selects as one nibble.
   assign sels = {lo_n, hi_n, cmd_n, ctl_n};
   int error_cnt = 0;                          // Mismatches seen.
   int comparisons = 0;                        // Comparisons made.
   // Rows: [19:16] xt,sec,en,x16_n; [15:12] lo,hi,cmd,ctl; [9:0] address.
   localparam logic [19:0] ROWS [20] = '{
      20'h211F0, 20'h351F7, 20'h263F6, 20'h263F7, 20'h2F1EF, 20'h2F1F8, 20'h2F170,
      20'h61170, 20'h61177, 20'h66376, 20'h66377, 20'h6F3F6, 20'h6F1F0,
      20'hA5320, 20'hA5323, 20'hAF324, 20'hAF31F, 20'hAE3F6, 20'hAF1F0, 20'h0F1F0};
   // ============================================================================
   // Clock at 50 MHz.
   always #10 clk = ~clk;
   iad_decode iad_decode_i (.clk(clk), .resetn(resetn), .host_addr(host_addr),
      .host_read_n(rd_n), .host_write_n(wr_n), .sixteen_bit_xfer_n(x16_n),
      .ide_addr_strap(strap), .floppy_disk_change(fdc), .ide_enable(en),
      .xt_mode(xt), .adapter_mode(adapter), .cfg_secondary(sec),
      .host_data_bit7_in(hbit7_in), .host_data_bit7_out(hb7_out),
      .host_data_bit7_oe_n(hb7_oe_n), .ide_data_bit7_in(ib7_in),
      .ide_data_bit7_out(ib7_out), .ide_data_bit7_oe_n(ib7_oe_n),
      .ide_low_byte_enable_n(lo_n), .ide_high_byte_enable_n(hi_n),
      .disk_select_cmd_n(cmd_n), .disk_select_ctl_n(ctl_n),
      .secondary_active(sec_act));
   iad_drive_model iad_drive_model_i (.want16_n(want16_n), .drive_bit7(drive_bit7),
      .ide_data_bit7_out(ib7_out), .ide_data_bit7_oe_n(ib7_oe_n),
      .sixteen_bit_xfer_n(x16_n), .ide_data_bit7_in(ib7_in));
   // ============================================================================
   // Checking and closing tasks.
   task automatic chk4(input logic [3:0] got, input logic [3:0] exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected selects at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected bit at %0t: got %b want %b", $time, got, exp);
      end
   endtask
   task automatic end_of_test();
      if (error_cnt == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // Waits well past the five-edge response of the pin path.
   task automatic settle();
      repeat (8) @(negedge clk);
   endtask
   // Resets with the strap held steady across the release.
   task automatic do_reset(input logic s);
      resetn = 1'b0;
      strap = s;
      repeat (16) @(negedge clk);
      resetn = 1'b1;
   endtask
   // ============================================================================
   // Watchdog: the tests need well under a thousand cycles.
   initial begin
      repeat (5000) @(posedge clk);
      error_cnt++;
      end_of_test();
   end
   // ============================================================================
   // Main sequence: reset, the table of decodes, then the hand-written cases.
   initial begin
      repeat (15) @(negedge clk);
      chk4({lo_n, hi_n, cmd_n, ctl_n}, 4'hF);
      @(negedge clk);
      resetn = 1'b1;
      // Each row holds address and mode long enough to pass the synchroniser.
      for (int i = 0; i < 20; i++) begin
         {xt, sec, en, want16_n} = ROWS[i][19:16];
         host_addr = ROWS[i][9:0];
         settle();
         chk4(sels, ROWS[i][15:12]);
      end
      // Read of the top control address returns the disk change status.
      {xt, sec, en, want16_n} = 4'h2;
      host_addr = 10'h3F7;
      rd_n = 1'b0;
      fdc = 1'b1;
      drive_bit7 = 1'b0;
      settle();
      chk1(hb7_oe_n, 1'b0);
      chk1(hb7_out, 1'b1);
      fdc = 1'b0;
      drive_bit7 = 1'b1;
      settle();
      chk1(hb7_out, 1'b0);
      // Elsewhere bit 7 is the drive's own, buffered to the host.
      host_addr = 10'h1F0;
      settle();
      chk1(hb7_out, 1'b1);
      rd_n = 1'b1;
      // A write carries host bit 7 to the drive; the drive's own level is
      // opposite so that a missing drive enable shows on the wire.
      wr_n = 1'b0;
      drive_bit7 = 1'b0;
      hbit7_in = 1'b1;
      settle();
      chk1(ib7_oe_n, 1'b0);
      chk1(ib7_in, 1'b1);
      wr_n = 1'b1;
      // XT mode never drives bit 7 on a read.
      xt = 1'b1;
      host_addr = 10'h320;
      rd_n = 1'b0;
      settle();
      chk1(hb7_oe_n, 1'b1);
      rd_n = 1'b1;
      xt = 1'b0;
      // Adapter mode: strap high at reset picks the secondary range.
      adapter = 1'b1;
      sec = 1'b0;
      do_reset(1'b1);
      host_addr = 10'h170;
      settle();
      chk1(sec_act, 1'b1);
      chk4({lo_n, hi_n, cmd_n, ctl_n}, 4'h1);
      // Strap low at reset overrides the held setting and picks primary.
      sec = 1'b1;
      do_reset(1'b0);
      host_addr = 10'h376;
      settle();
      chk1(sec_act, 1'b0);
      chk4({lo_n, hi_n, cmd_n, ctl_n}, 4'hF);
      // Without adapter mode the held setting decides.
      adapter = 1'b0;
      settle();
      chk1(sec_act, 1'b1);
      chk4({lo_n, hi_n, cmd_n, ctl_n}, 4'h6);
      end_of_test();
   end
endmodule // ide_address_decode_bench
`default_nettype wire
